// ==== design/hcc_cfg.svh ====
`ifndef HCC_CFG_SVH
`define HCC_CFG_SVH
// command and answer codes
`define HCC_CODE_PORT_WRITE   8'h0e
`define HCC_CODE_PORT_ACK     8'h0f
`define HCC_CODE_LINK_RATE    8'h10
`define HCC_CODE_RATE_ACK     8'h11
`define HCC_CODE_OPTIONS      8'h12
`define HCC_CODE_OPTIONS_ACK  8'h13
// port byte fields
`define HCC_APPLY_BIT         7
`define HCC_PORT_A_LSB        0
`define HCC_PORT_A_MSB        5
`define HCC_PORT_B_LSB        1
`define HCC_PORT_B_MSB        2
// rate codes
`define HCC_RATE_MAX          8'h08
`define HCC_RATE_RESET        4'h0
// option flag positions
`define HCC_FLAG_NODE_ADDR    0
`define HCC_FLAG_DEVICE_ID    1
`define HCC_FLAG_AUTO_ATTR    2
`define HCC_FLAG_RSVD_LO      3
`define HCC_FLAG_AUTO_SELECT  4
`define HCC_FLAG_CARD_EMUL    5
`define HCC_FLAG_PAD_SUPPRESS 6
`define HCC_FLAG_RSVD_HI      7
`define HCC_FLAGS_RESET       8'h34
// fixed values
`define HCC_DEVICE_ID_VALUE   8'h01
`define HCC_NODE_ADDR_STATUS  8'h80
// settle time after rate switch
`define HCC_SETTLE_US         200
`define HCC_CLK_MHZ           125
`define HCC_SETTLE_CYCLES     (`HCC_SETTLE_US * `HCC_CLK_MHZ)
`endif

// ==== design/hcc_pkg.sv ====
package hcc_pkg;
   typedef enum logic [2:0] {
      HCC_ANS_NONE    = 3'b001,
      HCC_ANS_OK      = 3'b010,
      HCC_ANS_SYNTAX  = 3'b100
   } hcc_kind_t;
   typedef enum logic [3:0] {
      HCC_ST_IDLE     = 4'b0001,
      HCC_ST_ANSWER   = 4'b0010,
      HCC_ST_WAIT_ACK = 4'b0100,
      HCC_ST_SETTLE   = 4'b1000
   } hcc_state_t;
endpackage

// ==== design/hcc_ctl_if.sv ====
`timescale 1ns/10ps
interface hcc_ctl_if;
   logic       rate_load;
   logic [3:0] rate_code;
   logic [3:0] rate_now;
   logic       settling;
   modport ctl (output rate_load, output rate_code, input rate_now, input settling);
   modport rate (input rate_load, input rate_code, output rate_now, output settling);
endinterface

// ==== design/hcc_rate_switch.sv ====
`timescale 1ns/10ps
`include "hcc_cfg.svh"
module hcc_rate_switch #(
   parameter int SETTLE_CYCLES = `HCC_SETTLE_CYCLES
) (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   hcc_ctl_if.rate   ctl
);
   typedef struct packed {
      logic [3:0]  rate;
      logic [15:0] count;
      logic        settling;
   } hcc_rs_t;
   hcc_rs_t st;
   hcc_rs_t next_st;
   always_comb begin
      next_st = st;
      if (ctl.rate_load) begin
         next_st.rate     = ctl.rate_code;
         next_st.count    = 16'(SETTLE_CYCLES);
         next_st.settling = 1'b1;
      end else if (st.count != 16'h0000) begin
         next_st.count = st.count - 16'h0001;
      end else begin
         next_st.settling = 1'b0;
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '{rate: `HCC_RATE_RESET, count: 16'h0000, settling: 1'b0};
      end else begin
         st <= next_st;
      end
   end
   assign ctl.rate_now = st.rate;
   assign ctl.settling = st.settling;
endmodule // hcc_rate_switch

// ==== design/hcc_config_handler.sv ====
`timescale 1ns/10ps
`include "hcc_cfg.svh"
// How it works
// - port write 0e, two bytes, answered 0f
// - bit 7 applies the whole port
// - port A bits 0..5 drive six pins
// - port B bits 1,2 used, bit0 zero
// - A pin2 is request line in handshake
// - A pin4 becomes companion activity line
// - rate command 10, codes 0..8
// - bad rate, link or length: syntax error
// - I2C or SPI link: application error
// - switch rate after answer and ACK
// - options 12, answered 13, length checked
// - flag bit map, bits 3,7 zero
// - node address byte only when enabled
// - received node address flags status bit7
// - device id byte fixed 01 when enabled
// - automatic attribute answer when flag set
// - automatic select request when flag set
// - card emulation answers when flag set
// - suppress frame padding when flag set
// - defaults: auto attr, auto select, emulation
module hcc_config_handler (
   // clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   // command stream: one parameter byte per strobe
   input  wire logic       i_cmd_start,
   input  wire logic [7:0] i_cmd_code,
   input  wire logic       i_cmd_byte_valid,
   input  wire logic [7:0] i_cmd_byte,
   input  wire logic       i_cmd_end,
   input  wire logic       i_host_ack,
   input  wire logic       i_answer_sent,
   // link configuration
   input  wire logic       i_link_is_fast_serial,
   input  wire logic       i_handshake_mode,
   input  wire logic       i_companion_mode,
   input  wire logic       i_handshake_req,
   input  wire logic       i_companion_active,
   // transport hooks
   input  wire logic       i_node_addr_received,
   // answer
   output logic            o_ans_valid,
   output logic [7:0]      o_ans_code,
   output logic            o_ans_syntax_err,
   output logic            o_ans_app_err,
   // pins
   output logic [5:0]      o_port_a,
   output logic [1:0]      o_port_b,
   // link rate
   output logic [3:0]      o_rate_code,
   output logic            o_rate_settling,
   // protocol options
   output logic            o_node_address_enable,
   output logic            o_device_id_enable,
   output logic            o_auto_attribute_response,
   output logic            o_auto_select_answer_request,
   output logic            o_card_emulation_enable,
   output logic            o_frame_padding_suppress,
   output logic [7:0]      o_device_id_value,
   output logic [7:0]      o_status_mark
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      // command collection; nbytes also marks answer sent while waiting
      hcc_pkg::hcc_state_t fsm;
      logic [7:0]          code;
      logic [1:0]          nbytes;
      logic [7:0]          b0;
      logic [7:0]          b1;
      logic [3:0]          pend_rate;
      // answer
      logic                ans_valid;
      logic [7:0]          ans_code;
      logic                syn_err;
      logic                app_err;
      // pins
      logic [5:0]          port_a;
      logic [1:0]          port_b;
      // options and rate
      logic [7:0]          flags;
      logic                rate_load;
      logic [3:0]          rate_out;
      logic                settling;
      // transport hooks
      logic [7:0]          mark;
      logic [7:0]          dev_id;
   } hcc_st_t;

   hcc_st_t st;
   hcc_st_t next_st;

   // ****************************************
   // rate switch
   // ****************************************
   // the switch sits apart so its settle counter can be sized alone
   hcc_ctl_if ctl ();
   hcc_rate_switch #(
      .SETTLE_CYCLES (`HCC_SETTLE_CYCLES)
   ) u_rate (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .ctl       (ctl)
   );
   // one-cycle load pulse carries the pending rate
   assign ctl.rate_load = st.rate_load;
   assign ctl.rate_code = st.pend_rate;

   // ****************************************
   // helpers
   // ****************************************
   // answer code is always the command code plus one
   function automatic logic [7:0] hcc_ans(input logic [7:0] code);
      hcc_ans = code + 8'h01;
   endfunction

   // apply bit of a port byte
   function automatic logic hcc_applies(input logic [7:0] b);
      hcc_applies = b[`HCC_APPLY_BIT];
   endfunction

   // six pin values of port A; bit 6 is dropped
   function automatic logic [5:0] hcc_port_a_of(input logic [7:0] b);
      hcc_port_a_of = b[`HCC_PORT_A_MSB:`HCC_PORT_A_LSB];
   endfunction

   // two usable pins of port B; bit 0 has no pin
   // the design trusts the host not to rewrite these under SPI
   function automatic logic [1:0] hcc_port_b_of(input logic [7:0] b);
      hcc_port_b_of = b[`HCC_PORT_B_MSB:`HCC_PORT_B_LSB];
   endfunction

   // byte count check shared by all three commands
   // two bits are enough: the count saturates at three
   function automatic logic hcc_len_bad(input logic [1:0] n, input logic [1:0] want);
      hcc_len_bad = (n != want);
   endfunction

   // rate byte beyond the table
   function automatic logic hcc_rate_bad(input logic [7:0] b);
      hcc_rate_bad = (b > `HCC_RATE_MAX);
   endfunction

   // reserved flag bits never reach the options register
   function automatic logic [7:0] hcc_flags_clean(input logic [7:0] b);
      hcc_flags_clean                    = b;
      hcc_flags_clean[`HCC_FLAG_RSVD_LO] = 1'b0;
      hcc_flags_clean[`HCC_FLAG_RSVD_HI] = 1'b0;
   endfunction

   // fixed device id byte follows its enable
   function automatic logic [7:0] hcc_dev_id(input logic [7:0] f);
      hcc_dev_id = f[`HCC_FLAG_DEVICE_ID] ? `HCC_DEVICE_ID_VALUE : 8'h00;
   endfunction

   // top status bit marks a node address in the payload
   function automatic logic [7:0] hcc_mark(input logic seen);
      hcc_mark = seen ? `HCC_NODE_ADDR_STATUS : 8'h00;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      // strobes fall back every cycle; levels hold unless written
      next_st           = st;
      next_st.ans_valid = 1'b0;
      next_st.rate_load = 1'b0;

      // rate and settle mirror the switch, one register late
      next_st.rate_out  = ctl.rate_now;
      next_st.settling  = ctl.settling;

      // status top bit follows a received node address
      next_st.mark      = hcc_mark(i_node_addr_received);

      case (st.fsm)
         // collect code and bytes, then judge on the end strobe
         hcc_pkg::HCC_ST_IDLE: begin
            if (i_cmd_start) begin
               // a new start abandons any half-collected command
               next_st.code   = i_cmd_code;
               next_st.nbytes = 2'd0;
            // a fourth byte is dropped; the count saturates at three
            end else if (i_cmd_byte_valid && st.nbytes != 2'd3) begin
               if (st.nbytes == 2'd0) begin
                  next_st.b0 = i_cmd_byte;
               end else if (st.nbytes == 2'd1) begin
                  next_st.b1 = i_cmd_byte;
               end
               next_st.nbytes = st.nbytes + 2'd1;
            end else if (i_cmd_end) begin
               // errors are cleared and judged again for every answer
               next_st.ans_valid = 1'b1;
               next_st.ans_code  = hcc_ans(st.code);
               next_st.syn_err   = 1'b0;
               next_st.app_err   = 1'b0;
               next_st.fsm       = hcc_pkg::HCC_ST_ANSWER;
               case (st.code)
                  `HCC_CODE_PORT_WRITE: begin
                     if (hcc_len_bad(st.nbytes, 2'd2)) begin
                        next_st.syn_err = 1'b1;
                     end else begin
                        // whole port or nothing: no single pin update
                        if (hcc_applies(st.b0)) begin
                           next_st.port_a = hcc_port_a_of(st.b0);
                        end
                        if (hcc_applies(st.b1)) begin
                           next_st.port_b = hcc_port_b_of(st.b1);
                        end
                     end
                  end
                  `HCC_CODE_LINK_RATE: begin
                     if (!i_link_is_fast_serial) begin
                        // refused on I2C or SPI before any byte check
                        next_st.app_err = 1'b1;
                        next_st.syn_err = 1'b1;
                     // length first, so a missing byte is never range checked
                     end else if (hcc_len_bad(st.nbytes, 2'd1)) begin
                        next_st.syn_err = 1'b1;
                     end else if (hcc_rate_bad(st.b0)) begin
                        next_st.syn_err = 1'b1;
                     end else begin
                        // held back until answer and ack both seen
                        next_st.pend_rate = st.b0[3:0];
                        next_st.fsm       = hcc_pkg::HCC_ST_WAIT_ACK;
                     end
                  end
                  `HCC_CODE_OPTIONS: begin
                     if (hcc_len_bad(st.nbytes, 2'd1)) begin
                        next_st.syn_err = 1'b1;
                     end else begin
                        // stored in one go; bits 3 and 7 forced low
                        next_st.flags = hcc_flags_clean(st.b0);
                     end
                  end
                  // unknown codes get no answer at all
                  default: begin
                     next_st.ans_valid = 1'b0;
                     next_st.fsm       = hcc_pkg::HCC_ST_IDLE;
                  end
               endcase
            end
         end

         // one cycle to let the answer strobe drop
         hcc_pkg::HCC_ST_ANSWER: begin
            next_st.fsm = hcc_pkg::HCC_ST_IDLE;
         end

         // old rate holds until answer out and host ACK both seen
         hcc_pkg::HCC_ST_WAIT_ACK: begin
            // the idle byte count doubles as the answer-sent memory
            // here, saving a flag; a new command clears it anyway
            if (i_answer_sent) begin
               next_st.nbytes = 2'd3;
            end
            // ack may come with the send or any time after it
            if (i_host_ack && (st.nbytes == 2'd3 || i_answer_sent)) begin
               next_st.rate_load = 1'b1;
               next_st.nbytes    = 2'd0;
               next_st.fsm       = hcc_pkg::HCC_ST_SETTLE;
            end
         end

         // the load pulse hands the switch the new rate at this cycle's end; the host waits out the settle
         hcc_pkg::HCC_ST_SETTLE: begin
            next_st.fsm = hcc_pkg::HCC_ST_IDLE;
         end

         // stray codes after an upset fall back to idle
         default: begin
            next_st.fsm = hcc_pkg::HCC_ST_IDLE;
         end
      endcase

      // shared pins taken over by their special functions
      // a takeover wins over a port write in the same cycle
      if (i_handshake_mode) begin
         next_st.port_a[2] = i_handshake_req;
      end
      if (i_companion_mode) begin
         next_st.port_a[4] = i_companion_active;
      end
      // registered so the device id value never lags its flag
      next_st.dev_id = hcc_dev_id(next_st.flags);
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // options come up at their defaults, fsm at idle, all else cleared
         // pending rate starts at the lowest code
         st           <= '0;
         st.fsm       <= hcc_pkg::HCC_ST_IDLE;
         st.flags     <= `HCC_FLAGS_RESET;
         st.pend_rate <= `HCC_RATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // every output is a bare register field
   // answer
   assign o_ans_valid                  = st.ans_valid;
   assign o_ans_code                   = st.ans_code;
   assign o_ans_syntax_err             = st.syn_err;
   assign o_ans_app_err                = st.app_err;

   // pins
   assign o_port_a                     = st.port_a;
   assign o_port_b                     = st.port_b;

   // link rate
   assign o_rate_code                  = st.rate_out;
   assign o_rate_settling              = st.settling;

   // protocol options
   assign o_node_address_enable        = st.flags[`HCC_FLAG_NODE_ADDR];
   assign o_device_id_enable           = st.flags[`HCC_FLAG_DEVICE_ID];
   assign o_auto_attribute_response    = st.flags[`HCC_FLAG_AUTO_ATTR];
   assign o_auto_select_answer_request = st.flags[`HCC_FLAG_AUTO_SELECT];
   assign o_card_emulation_enable      = st.flags[`HCC_FLAG_CARD_EMUL];
   assign o_frame_padding_suppress     = st.flags[`HCC_FLAG_PAD_SUPPRESS];
   assign o_device_id_value            = st.dev_id;

   // transport hooks
   assign o_status_mark                = st.mark;
endmodule // hcc_config_handler

// ==== verification/hcc_chk_checker.sv ====
`timescale 1ns/10ps
// ****
// answer, port, rate, option and status checker
// ****
module hcc_chk (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic       i_cmd_end,
   input  wire logic       i_node_addr_received,
   input  wire logic       o_ans_valid,
   input  wire logic [7:0] o_ans_code,
   input  wire logic       o_ans_syntax_err,
   input  wire logic       o_ans_app_err,
   input  wire logic [1:0] o_port_b,
   input  wire logic [3:0] o_rate_code,
   input  wire logic       o_rate_settling,
   input  wire logic       o_device_id_enable,
   input  wire logic [7:0] o_device_id_value,
   input  wire logic       o_node_address_enable,
   input  wire logic [7:0] o_status_mark
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_rate_ok;
      o_ans_valid && o_ans_code == 8'h11 && !o_ans_syntax_err;
   endsequence
   sequence s_switch;
      $changed(o_rate_code);
   endsequence
   AST_ANS_PULSE: assert property (o_ans_valid |=> !o_ans_valid)
      else $error("answer strobe held");
   AST_ANS_CAUSE: assert property (o_ans_valid |-> $past(i_cmd_end))
      else $error("answer without command end");
   AST_PORT_B_CAUSE: assert property ($changed(o_port_b) |-> o_ans_valid && o_ans_code == 8'h0f)
      else $error("port b moved outside port write");
   AST_RATE_HOLD: assert property (s_rate_ok |=> $stable(o_rate_code) [*2])
      else $error("rate switched before ack");
   AST_SWITCH_SETTLE: assert property (s_switch |-> o_rate_settling [*8])
      else $error("settle flag missing after switch");
   AST_RATE_MAX: assert property (o_rate_code <= 4'h8)
      else $error("rate code out of range");
   AST_APP_SYNTAX: assert property (o_ans_app_err |-> o_ans_syntax_err)
      else $error("app error without syntax error");
   AST_DEV_ID: assert property (o_device_id_value == (o_device_id_enable ? 8'h01 : 8'h00))
      else $error("device id value wrong");
   AST_STATUS: assert property ($past(i_rst_n) |-> o_status_mark == ($past(i_node_addr_received) ? 8'h80 : 8'h00))
      else $error("status mark wrong");
   AST_FLAG_CAUSE: assert property ($changed(o_node_address_enable) |-> o_ans_valid && o_ans_code == 8'h13)
      else $error("flag moved outside option command");
endmodule // hcc_chk

bind hcc_config_handler hcc_chk u_chk (.*);

// ==== verification/hcc_host_model.sv ====
`timescale 1ns/10ps
// ****
// host side: answer transmit and ack
// ****
module hcc_host_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic       i_ans_valid,
   input  wire logic [7:0] i_ans_code,
   input  wire logic       i_ans_err,
   input  wire logic       i_slow,
   output logic            o_answer_sent,
   output logic            o_host_ack
);
   int   cnt;
   logic need_ack;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= 0;
         need_ack <= 1'b0;
         o_answer_sent <= 1'b0;
         o_host_ack <= 1'b0;
      end else begin
         cnt <= i_ans_valid ? 1 : (cnt != 0 && cnt < 64) ? cnt + 1 : 0;
         if (i_ans_valid) begin
            need_ack <= (i_ans_code == 8'h11) && !i_ans_err;
         end
         o_answer_sent <= (cnt == 3);
         // prompt ack coincides with the send, slow one lags far behind
         o_host_ack <= need_ack && cnt == (i_slow ? 40 : 3);
      end
   end
endmodule // hcc_host_model

// ==== verification/hcc_config_handler_tb.sv ====
`timescale 1ns/10ps
module hcc_config_handler_tb;
   logic i_clk_sys, i_rst_n, i_cmd_start, i_cmd_byte_valid, i_cmd_end, i_host_ack;
   logic i_answer_sent, i_link_is_fast_serial, i_handshake_mode, i_companion_mode;
   logic i_handshake_req, i_companion_active, i_node_addr_received, slow;
   logic o_ans_valid, o_ans_syntax_err, o_ans_app_err, o_rate_settling;
   logic o_node_address_enable, o_device_id_enable, o_auto_attribute_response;
   logic o_auto_select_answer_request, o_card_emulation_enable, o_frame_padding_suppress;
   logic [7:0] i_cmd_code, i_cmd_byte, o_ans_code, o_device_id_value, o_status_mark;
   logic [7:0] code, b0, b1;
   logic [5:0] o_port_a, ea;
   logic [1:0] o_port_b, eb;
   logic [3:0] o_rate_code, old;
   logic       syn, app;
   int         n_fail, checks_done, cyc, k;
   hcc_config_handler dut (.*);
   hcc_host_model host (.i_clk_sys, .i_rst_n, .i_ans_valid(o_ans_valid),
      .i_ans_code(o_ans_code), .i_ans_err(o_ans_syntax_err), .i_slow(slow),
      .o_answer_sent(i_answer_sent), .o_host_ack(i_host_ack));
   // ****
   // clock, timeout, background traffic
   // ****
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc > 90000) begin
         n_fail++;
         close_out();
      end
   end
   always @(posedge i_clk_sys) #1 i_node_addr_received = 1'($urandom);
   // ****
   // helpers
   // ****
   task step;
      @(posedge i_clk_sys);
      #1;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   function automatic logic [7:0] flg();
      return {1'b0, o_frame_padding_suppress, o_card_emulation_enable,
         o_auto_select_answer_request, 1'b0, o_auto_attribute_response,
         o_device_id_enable, o_node_address_enable};
   endfunction
   // a port byte without its apply bit leaves the port alone
   function automatic logic [5:0] fa(logic [5:0] o, logic [7:0] b);
      return b[7] ? b[5:0] : o;
   endfunction
   function automatic logic [1:0] fb(logic [1:0] o, logic [7:0] b);
      return b[7] ? b[2:1] : o;
   endfunction
   task cmd(input logic [7:0] c, input int n, input logic [7:0] x, input logic [7:0] y);
      i_cmd_start = 1'b1;
      i_cmd_code = c;
      step;
      i_cmd_start = 1'b0;
      for (int j = 0; j < n; j++) begin
         i_cmd_byte_valid = 1'b1;
         i_cmd_byte = j ? y : x;
         step;
      end
      i_cmd_byte_valid = 1'b0;
      i_cmd_end = 1'b1;
      step;
      i_cmd_end = 1'b0;
      for (int j = 0; j < 8 && o_ans_valid !== 1'b1; j++) step;
      chk("answer", 1, o_ans_valid);
      code = o_ans_code;
      syn = o_ans_syntax_err;
      app = o_ans_app_err;
      step;
      step;
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ****
   // tests
   // ****
   initial begin
      {i_cmd_start, i_cmd_byte_valid, i_cmd_end, i_handshake_mode, slow} = 5'h00;
      {i_companion_mode, i_handshake_req, i_companion_active, i_rst_n} = 4'h0;
      {i_cmd_code, i_cmd_byte} = 16'h0000;
      i_link_is_fast_serial = 1'b1;
      void'($urandom(44043));
      repeat (3) @(posedge i_clk_sys);
      #1 i_rst_n = 1'b1;
      chk("default flags", 8'h34, flg());
      {ea, eb} = 8'h00;
      for (int i = 0; i < 10; i++) begin
         b0 = i ? $urandom : 8'h83;
         b1 = i ? $urandom : 8'h00;
         ea = fa(ea, b0);
         eb = fb(eb, b1);
         cmd(8'h0e, 2, b0, b1);
         chk("port code", 8'h0f, code);
         chk("port a", ea, o_port_a);
         chk("port b", eb, o_port_b);
      end
      {i_handshake_mode, i_handshake_req, i_companion_mode} = 3'b111;
      cmd(8'h0e, 2, 8'hbf, 8'h00);
      chk("request pin", 1, o_port_a[2]);
      chk("activity pin", 0, o_port_a[4]);
      {i_handshake_mode, i_handshake_req, i_companion_mode} = 3'b000;
      cmd(8'h0e, 1, 8'h80, 8'h00);
      chk("short port write", 1, syn);
      $display("test port write done");
      for (int i = 0; i < 8; i++) begin
         b0 = i ? $urandom : 8'hff;
         cmd(8'h12, 1, b0, 8'h00);
         chk("option code", 8'h13, code);
         chk("flags", b0 & 8'h77, flg());
      end
      cmd(8'h12, 0, 8'h00, 8'h00);
      chk("missing flags", 1, syn);
      cmd(8'h12, 2, 8'h00, 8'h00);
      chk("long options", 1, syn);
      chk("flags kept", b0 & 8'h77, flg());
      $display("test options done");
      cmd(8'h10, 1, 8'h09, 8'h00);
      chk("rate above 8", 1, syn);
      cmd(8'h10, 0, 8'h00, 8'h00);
      chk("rate missing", 1, syn);
      i_link_is_fast_serial = 1'b0;
      cmd(8'h10, 1, 8'h04, 8'h00);
      chk("slow link syntax", 1, syn);
      chk("slow link app", 1, app);
      i_link_is_fast_serial = 1'b1;
      chk("rate kept", 0, o_rate_code);
      for (int i = 0; i < 3; i++) begin
         b0 = (i == 0) ? 8'h08 : (i == 1) ? 8'h00 : 8'h01 + $urandom % 7;
         slow = ~i[0];
         old = o_rate_code;
         cmd(8'h10, 1, b0, 8'h00);
         chk("rate code", 8'h11, code);
         for (k = 0; k < 60 && i_host_ack !== 1'b1; k++) step;
         chk("rate before ack", old, o_rate_code);
         repeat (3) step;
         chk("new rate", b0[3:0], o_rate_code);
         // settle must cover 200 us at 125 cycles per us from the ack
         for (k = 0; k < 30000 && o_rate_settling === 1'b1; k++) step;
         chk("settle span", 1, k + 3 >= 200 * 125);
      end
      $display("test rate done");
      close_out();
   end
endmodule // hcc_config_handler_tb
